// ===== inc/bsr_pkg.sv
// shared constants, modes and word formats of the strip readout block
// assumes: one 100 MHz crossing clock, 128 discriminator channels per chip
package bsr_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NCHAN = 128; // discriminator channels
	localparam int CHAN_W = 7; // channel address width
	localparam int PIPE_DEPTH = 128; // latency pipeline entries
	localparam int PIPE_AW = 7; // pipeline index width
	localparam int EVT_DEPTH = 8; // derandomising buffer events
	localparam int EVT_AW = 3; // event index width
	localparam int EVT_CW = 4; // event count width
	localparam int TAG_W = 8; // trigger tag width
	localparam int ID_W = 4; // chip identifier width
	localparam int CHAIN_LEN = 6; // chips on one side of a module
	localparam int LATENCY_DEF = 100; // default trigger latency in crossings
	localparam int OUT_DEPTH = 2; // output buffer entries

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10; // crossing clock period
	localparam int TOKEN_PULSE_CYC = 1; // token out pulse length

	// ----------------------------------------------------------------
	// error codes carried in an error word
	// ----------------------------------------------------------------
	localparam logic [CHAN_W-1:0] ERR_NO_DATA = 7'h00; // readout with empty buffer
	localparam logic [CHAN_W-1:0] ERR_OVERFLOW = 7'h01; // oldest event overwritten
	localparam logic [CHAN_W-1:0] ERR_BUFFER = 7'h02; // bookkeeping lost
	localparam logic [CHAN_W-1:0] ERR_CONFIG = 7'h03; // configuration error

	// selection modes
	typedef enum logic [1:0] {
		MODE_LEVEL,
		MODE_EDGE,
		MODE_HIT,
		MODE_READ_EVERY_CHANNEL
	} bsr_mode_t;

	// kinds of output word
	typedef enum logic [1:0] {
		WK_HEADER,
		WK_HIT,
		WK_TRAILER,
		WK_ERROR
	} bsr_kind_t;

	// one output word of the chain
	typedef struct packed {
		bsr_kind_t kind; // word kind
		logic lost; // header: events lost before this one
		logic [TAG_W-1:0] tag; // header: trigger tag, error: chip identifier
		logic [CHAN_W-1:0] chan; // hit: channel, error: code
		logic [2:0] bits; // hit: preceding, triggered, following
	} bsr_word_t;

	// one buffered trigger event
	typedef struct packed {
		logic [TAG_W-1:0] tag; // trigger tag
		logic lost; // overwrite happened on entry
		logic [NCHAN-1:0] prev; // crossing before the trigger
		logic [NCHAN-1:0] trig; // triggered crossing
		logic [NCHAN-1:0] next; // crossing after the trigger
	} bsr_event_t;

endpackage

// ===== hdl/bsr_out_buffer.sv
// small output buffer between the readout engine and the chain output
// assumes: one clock, drain side may stall at any time
`timescale 1ns/100ps
module bsr_out_buffer #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH]; // storage
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [PW-1:0] wr_r, wr_nxt; // write index
	logic [PW-1:0] rd_r, rd_nxt; // read index
	logic [CW-1:0] cnt_r, cnt_nxt; // words held
	logic rdy_r, rdy_nxt; // registered ready
	logic vld_r, vld_nxt; // registered valid
	logic [WIDTH-1:0] dat_r, dat_nxt; // registered head word
	logic push, pop;

	// wrap an index
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		push = in_valid && rdy_r;
		pop = vld_r && out_ready;
		mem_nxt = mem_r;
		if (push) begin
			mem_nxt[wr_r] = in_data;
		end
		wr_nxt = push ? bump(wr_r) : wr_r;
		rd_nxt = pop ? bump(rd_r) : rd_r;
		cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
		rdy_nxt = cnt_nxt < CW'(DEPTH);
		vld_nxt = cnt_nxt != '0;
		dat_nxt = mem_nxt[rd_nxt];
	end

	// registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b1;
			vld_r <= 1'b0;
			dat_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
			vld_r <= vld_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign in_ready = rdy_r;
	assign out_valid = vld_r;
	assign out_data = dat_r;
endmodule

// ===== hdl/bsr_readout.sv
// strip readout: latency pipeline, event buffer, selection, chain output
// assumes: hits synchronous to mclk, token and words from chain neighbours
// Operation
// - sample all 128 hits every clock
// - pipeline 128 deep, one bit per channel
// - on trigger copy triggered crossing and neighbours
// - derandomising buffer holds eight events
// - send only qualifying channels normally
// - level mode uses triggered crossing only
// - edge mode needs zero in preceding crossing
// - hit mode needs one in any crossing
// - read every channel mode sends all
// - compress buffered data before sending
// - six chips share output via token
// - error when readout finds no event
// - full buffer overwrites oldest, reports overflow
// - bookkeeping error sticky until chip reset
// - configuration error sends chip identifier
// - lost events marked in output stream
// - never send data under wrong trigger
// - token and data may bypass failed neighbour
// - programmable pattern through pipeline and readout
`timescale 1ns/100ps
module bsr_readout #(
	parameter int LATENCY = bsr_pkg::LATENCY_DEF
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// front end
	input wire logic [bsr_pkg::NCHAN-1:0] hit_in,
	// trigger and control
	input wire logic first_level_trigger,
	input wire bsr_pkg::bsr_mode_t sel_mode,
	input wire logic [bsr_pkg::ID_W-1:0] chip_identifier,
	input wire logic config_error,
	input wire logic test_enable,
	input wire logic [bsr_pkg::NCHAN-1:0] test_pattern,
	input wire logic bypass_sel,
	// token chain
	input wire logic token_in,
	input wire logic token_bypass_in,
	output logic token_out,
	// words from upstream chips
	input wire logic up_valid,
	input wire bsr_pkg::bsr_word_t up_word,
	input wire logic up_bypass_valid,
	input wire bsr_pkg::bsr_word_t up_bypass_word,
	output logic up_ready,
	// words to downstream
	output logic down_valid,
	input wire logic down_ready,
	output bsr_pkg::bsr_word_t down_word,
	// status
	output logic buf_error
);
	localparam logic [bsr_pkg::PIPE_AW-1:0] LAT = bsr_pkg::PIPE_AW'(LATENCY);

	typedef enum logic [2:0] {ST_IDLE, ST_ERR, ST_HEAD, ST_SCAN, ST_TRAIL, ST_PASS} bsr_state_t;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [bsr_pkg::NCHAN-1:0] in_r, in_nxt; // input sample register
	logic [bsr_pkg::NCHAN-1:0] pipe_r [bsr_pkg::PIPE_DEPTH]; // latency pipeline
	logic [bsr_pkg::NCHAN-1:0] pipe_nxt [bsr_pkg::PIPE_DEPTH];
	logic [bsr_pkg::PIPE_AW-1:0] slot_wr_r, slot_wr_nxt; // beam_crossing_slot write index
	logic [bsr_pkg::PIPE_AW-1:0] idx_t, idx_p, idx_n; // trigger and neighbour slots
	bsr_pkg::bsr_event_t evt_r [bsr_pkg::EVT_DEPTH]; // event buffer
	bsr_pkg::bsr_event_t evt_nxt [bsr_pkg::EVT_DEPTH];
	logic [bsr_pkg::EVT_AW-1:0] ewr_r, ewr_nxt, erd_r, erd_nxt; // event indices
	logic [bsr_pkg::EVT_CW-1:0] ecnt_r, ecnt_nxt; // events held
	logic [bsr_pkg::TAG_W-1:0] tcnt_r, tcnt_nxt; // trigger tag counter
	logic ovf_r, ovf_nxt; // overflow waiting to be reported
	logic buf_err_r, buf_err_nxt; // sticky bookkeeping error
	logic full, pop, tok;
	bsr_pkg::bsr_event_t cur_r, cur_nxt; // event being read out
	bsr_state_t st_r, st_nxt; // readout state
	logic [bsr_pkg::CHAN_W-1:0] chan_r, chan_nxt; // scan channel
	logic [bsr_pkg::CHAN_W-1:0] errc_r, errc_nxt; // pending error code
	logic go_head_r, go_head_nxt; // read event after error word
	logic tok_out_r, tok_out_nxt; // token out pulse
	logic up_rdy_r, up_rdy_nxt; // upstream ready
	logic own_v, fwd_v, q, buf_in_ready, buf_in_valid;
	bsr_pkg::bsr_word_t own_w, fwd_w, buf_in_word;

	// channel selection under a mode
	function automatic logic qualify(input bsr_pkg::bsr_mode_t m, input logic p, input logic t, input logic n);
		case (m)
			bsr_pkg::MODE_LEVEL: qualify = t;
			bsr_pkg::MODE_EDGE: qualify = !p && t;
			bsr_pkg::MODE_HIT: qualify = p || t || n;
			default: qualify = 1'b1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// input register and latency pipeline
	// ----------------------------------------------------------------
	// sample hits or the test pattern, write oldest slot
	always_comb begin
		in_nxt = test_enable ? test_pattern : hit_in;
		pipe_nxt = pipe_r;
		pipe_nxt[slot_wr_r] = in_r;
		slot_wr_nxt = bsr_pkg::PIPE_AW'(slot_wr_r + 1'b1);
		idx_t = bsr_pkg::PIPE_AW'(slot_wr_r - LAT);
		idx_p = bsr_pkg::PIPE_AW'(idx_t - 1'b1);
		idx_n = bsr_pkg::PIPE_AW'(idx_t + 1'b1);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			in_r <= '0;
			for (int i = 0; i < bsr_pkg::PIPE_DEPTH; i++) begin
				pipe_r[i] <= '0;
			end
			slot_wr_r <= '0;
		end else begin
			in_r <= in_nxt;
			pipe_r <= pipe_nxt;
			slot_wr_r <= slot_wr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// derandomising event buffer
	// ----------------------------------------------------------------
	// store on trigger, remove on token, overwrite oldest when full
	always_comb begin
		tok = bypass_sel ? token_bypass_in : token_in;
		pop = (st_r == ST_IDLE) && tok && (ecnt_r != '0);
		full = (ecnt_r == bsr_pkg::EVT_CW'(bsr_pkg::EVT_DEPTH)) && !pop;
		evt_nxt = evt_r;
		ewr_nxt = ewr_r;
		erd_nxt = erd_r;
		ecnt_nxt = ecnt_r;
		tcnt_nxt = tcnt_r;
		ovf_nxt = ovf_r;
		cur_nxt = pop ? evt_r[erd_r] : cur_r;
		// overflow report clears first so a new overflow wins
		if (st_r == ST_ERR && errc_r == bsr_pkg::ERR_OVERFLOW && buf_in_ready) begin
			ovf_nxt = 1'b0;
		end
		// take oldest event out
		if (pop) begin
			erd_nxt = bsr_pkg::EVT_AW'(erd_r + 1'b1);
			ecnt_nxt = bsr_pkg::EVT_CW'(ecnt_r - 1'b1);
		end
		// trigger copies three crossings with its own tag
		if (first_level_trigger) begin
			evt_nxt[ewr_r].tag = tcnt_r;
			evt_nxt[ewr_r].lost = full;
			evt_nxt[ewr_r].prev = pipe_r[idx_p];
			evt_nxt[ewr_r].trig = pipe_r[idx_t];
			evt_nxt[ewr_r].next = pipe_r[idx_n];
			ewr_nxt = bsr_pkg::EVT_AW'(ewr_r + 1'b1);
			tcnt_nxt = bsr_pkg::TAG_W'(tcnt_r + 1'b1);
			if (full) begin
				erd_nxt = bsr_pkg::EVT_AW'(erd_r + 1'b1);
				ovf_nxt = 1'b1;
			end else begin
				ecnt_nxt = bsr_pkg::EVT_CW'(ecnt_nxt + 1'b1);
			end
		end
		// count must match the index distance
		buf_err_nxt = buf_err_r || (ecnt_r > bsr_pkg::EVT_CW'(bsr_pkg::EVT_DEPTH))
			|| (ecnt_r[bsr_pkg::EVT_AW-1:0] != bsr_pkg::EVT_AW'(ewr_r - erd_r));
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < bsr_pkg::EVT_DEPTH; i++) begin
				evt_r[i] <= '0;
			end
			ewr_r <= '0;
			erd_r <= '0;
			ecnt_r <= '0;
			tcnt_r <= '0;
			ovf_r <= 1'b0;
			buf_err_r <= 1'b0;
			cur_r <= '0;
		end else begin
			evt_r <= evt_nxt;
			ewr_r <= ewr_nxt;
			erd_r <= erd_nxt;
			ecnt_r <= ecnt_nxt;
			tcnt_r <= tcnt_nxt;
			ovf_r <= ovf_nxt;
			buf_err_r <= buf_err_nxt;
			cur_r <= cur_nxt;
		end
	end

	// ----------------------------------------------------------------
	// readout engine and chain forwarding
	// ----------------------------------------------------------------
	// while holding the token send own words, otherwise forward upstream
	always_comb begin
		st_nxt = st_r;
		chan_nxt = chan_r;
		errc_nxt = errc_r;
		go_head_nxt = go_head_r;
		own_v = 1'b0;
		own_w = '0;
		q = qualify(sel_mode, cur_r.prev[chan_r], cur_r.trig[chan_r], cur_r.next[chan_r]);
		case (st_r)
			ST_IDLE: begin
				// token arrival starts this chip's turn
				if (tok) begin
					st_nxt = ST_ERR;
					go_head_nxt = 1'b0;
					if (buf_err_r) begin
						errc_nxt = bsr_pkg::ERR_BUFFER;
					end else if (config_error) begin
						errc_nxt = bsr_pkg::ERR_CONFIG;
						go_head_nxt = ecnt_r != '0;
					end else if (ecnt_r == '0) begin
						errc_nxt = bsr_pkg::ERR_NO_DATA;
					end else if (ovf_r) begin
						errc_nxt = bsr_pkg::ERR_OVERFLOW;
						go_head_nxt = 1'b1;
					end else begin
						st_nxt = ST_HEAD;
					end
				end
			end
			ST_ERR: begin
				// error word carries chip identifier and code
				own_v = 1'b1;
				own_w.kind = bsr_pkg::WK_ERROR;
				own_w.tag = bsr_pkg::TAG_W'(chip_identifier);
				own_w.chan = errc_r;
				if (buf_in_ready) begin
					st_nxt = go_head_r ? ST_HEAD : ST_PASS;
				end
			end
			ST_HEAD: begin
				// header carries the event's own tag
				own_v = 1'b1;
				own_w.kind = bsr_pkg::WK_HEADER;
				own_w.lost = cur_r.lost;
				own_w.tag = cur_r.tag;
				if (buf_in_ready) begin
					st_nxt = ST_SCAN;
					chan_nxt = '0;
				end
			end
			ST_SCAN: begin
				// only qualifying channels become words
				own_v = q;
				own_w.kind = bsr_pkg::WK_HIT;
				own_w.chan = chan_r;
				own_w.bits = {cur_r.prev[chan_r], cur_r.trig[chan_r], cur_r.next[chan_r]};
				if (!q || buf_in_ready) begin
					if (chan_r == bsr_pkg::CHAN_W'(bsr_pkg::NCHAN - 1)) begin
						st_nxt = ST_TRAIL;
					end else begin
						chan_nxt = bsr_pkg::CHAN_W'(chan_r + 1'b1);
					end
				end
			end
			ST_TRAIL: begin
				own_v = 1'b1;
				own_w.kind = bsr_pkg::WK_TRAILER;
				if (buf_in_ready) begin
					st_nxt = ST_PASS;
				end
			end
			ST_PASS: begin
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		fwd_w = bypass_sel ? up_bypass_word : up_word;
		fwd_v = up_rdy_r && (bypass_sel ? up_bypass_valid : up_valid);
		buf_in_valid = own_v || fwd_v;
		buf_in_word = own_v ? own_w : fwd_w;
		// at most one forwarded word every other cycle keeps room assured
		up_rdy_nxt = (st_nxt == ST_IDLE) && !buf_in_valid && buf_in_ready;
		tok_out_nxt = st_r == ST_PASS;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_IDLE;
			chan_r <= '0;
			errc_r <= '0;
			go_head_r <= 1'b0;
			tok_out_r <= 1'b0;
			up_rdy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			chan_r <= chan_nxt;
			errc_r <= errc_nxt;
			go_head_r <= go_head_nxt;
			tok_out_r <= tok_out_nxt;
			up_rdy_r <= up_rdy_nxt;
		end
	end

	// output buffer absorbs a downstream stall
	bsr_out_buffer #(
		.WIDTH($bits(bsr_pkg::bsr_word_t)),
		.DEPTH(bsr_pkg::OUT_DEPTH)
	) u_out (
		.mclk(mclk),
		.nrst(nrst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_word),
		.out_valid(down_valid),
		.out_ready(down_ready),
		.out_data(down_word)
	);

	assign token_out = tok_out_r;
	assign up_ready = up_rdy_r;
	assign buf_error = buf_err_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_trail_sent;
		st_r == ST_TRAIL && buf_in_ready;
	endsequence
	sequence s_pass_then_token;
		st_r == ST_PASS ##1 tok_out_r;
	endsequence

	a_input_capture: assert property (##1 in_r == $past(test_enable ? test_pattern : hit_in))
		else $error("input sample mismatch");
	a_pipe_write: assert property (##1 pipe_r[$past(slot_wr_r)] == $past(in_r))
		else $error("pipeline slot not written");
	a_trig_count: assert property (first_level_trigger && !full && !pop |=> ecnt_r == $past(ecnt_r) + 1'b1)
		else $error("event count did not grow");
	a_overflow_lost: assert property (first_level_trigger && full |=> ovf_r && ecnt_r == 4'h8 && evt_r[$past(ewr_r)].lost)
		else $error("overflow not flagged");
	a_trig_tag: assert property (first_level_trigger |=> evt_r[$past(ewr_r)].tag == $past(tcnt_r))
		else $error("event tag wrong");
	a_nodata_err: assert property (st_r == ST_IDLE && tok && ecnt_r == '0 && !buf_err_r && !config_error
		|=> st_r == ST_ERR && errc_r == bsr_pkg::ERR_NO_DATA && own_v && own_w.kind == bsr_pkg::WK_ERROR)
		else $error("empty readout not reported");
	a_buf_err_hold: assert property (buf_err_r |=> buf_err_r [*2])
		else $error("buffer error cleared");
	a_hit_select: assert property (st_r == ST_SCAN && buf_in_valid && buf_in_ready |-> buf_in_word.kind == bsr_pkg::WK_HIT
		&& qualify(sel_mode, buf_in_word.bits[2], buf_in_word.bits[1], buf_in_word.bits[0]))
		else $error("unqualified channel sent");
	a_header_tag: assert property (st_r == ST_HEAD && buf_in_ready |-> buf_in_valid && buf_in_word.tag == cur_r.tag
		&& buf_in_word.lost == cur_r.lost)
		else $error("header tag differs from event");
	a_config_id: assert property (st_r == ST_ERR && errc_r == bsr_pkg::ERR_CONFIG |-> own_w.tag[3:0] == chip_identifier)
		else $error("chip identifier missing");
	a_token_pass: assert property (s_trail_sent |=> s_pass_then_token ##1 !tok_out_r)
		else $error("token not passed after trailer");
endmodule

// ===== verification/bsr_chain_model.sv
// neighbour chips: token source, upstream word source, downstream sink
// assumes: tb_top reads rx and sets hold and slow at the falling edge
`timescale 1ns/100ps
module bsr_chain_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// tokens towards the chip
	output logic token_in,
	output logic token_bypass_in,
	// upstream words
	output logic up_valid,
	output bsr_pkg::bsr_word_t up_word,
	output logic up_bypass_valid,
	output bsr_pkg::bsr_word_t up_bypass_word,
	input wire logic up_ready,
	// downstream sink
	input wire logic down_valid,
	input wire bsr_pkg::bsr_word_t down_word,
	output logic down_ready
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic hold = 1'b0; // sink refuses all words
	logic slow = 1'b0; // sink takes every other cycle
	logic phase = 1'b0; // stall phase
	int timeouts = 0; // offers never taken
	bsr_pkg::bsr_word_t rx[$]; // words seen downstream

	// quiet lines at time zero
	initial begin
		token_in = 1'b0;
		token_bypass_in = 1'b0;
		up_valid = 1'b0;
		up_bypass_valid = 1'b0;
		up_word = 21'h0;
		up_bypass_word = 21'h0;
		down_ready = 1'b0;
	end

	// sink readiness moves only after the falling edge
	always @(negedge mclk) begin
		phase <= ~phase;
		down_ready <= !hold && !(slow && phase);
	end

	// collect every word handed over
	always @(posedge mclk) begin
		if (nrst && down_valid && down_ready) begin
			rx.push_back(down_word);
		end
	end

	// one-cycle token on the chosen line
	task automatic give_token(input logic byp);
		@(negedge mclk);
		if (byp) begin
			token_bypass_in = 1'b1;
		end else begin
			token_in = 1'b1;
		end
		@(negedge mclk);
		token_in = 1'b0;
		token_bypass_in = 1'b0;
	endtask

	// offer one word until taken or 200 cycles pass; a released line shows the inverse
	task automatic send_up(input bsr_pkg::bsr_word_t w, input logic byp);
		int i;
		@(negedge mclk);
		if (byp) begin
			up_bypass_valid = 1'b1;
			up_bypass_word = w;
		end else begin
			up_valid = 1'b1;
			up_word = w;
		end
		for (i = 0; i < 200; i++) begin
			@(posedge mclk);
			if (up_ready === 1'b1) break;
		end
		if (i == 200) timeouts++;
		@(negedge mclk);
		up_valid = 1'b0;
		up_bypass_valid = 1'b0;
		up_word = ~up_word;
		up_bypass_word = ~up_bypass_word;
	endtask
endmodule

// ===== verification/tb_top.sv
// top bench: resets the readout block, runs each scenario, reports verdict
// assumes: bsr_chain_model stands for the neighbouring chips
`timescale 1ns/100ps
module tb_top;
	localparam int LAT = 4; // short trigger latency
	localparam logic [127:0] PV = 128'h00000000_00000001_00000002_00000020; // preceding
	localparam logic [127:0] TV = 128'h80000000_00000000_00000002_00000021; // triggered
	localparam logic [127:0] NV = 128'h80000000_00000000_00000002_00000200; // following
	logic mclk, nrst, first_level_trigger, config_error, test_enable, bypass_sel;
	logic [127:0] hit_in, test_pattern;
	bsr_pkg::bsr_mode_t sel_mode;
	logic [3:0] chip_identifier;
	logic token_in, token_bypass_in, token_out, up_valid, up_bypass_valid, up_ready;
	logic down_valid, down_ready, buf_error;
	bsr_pkg::bsr_word_t up_word, up_bypass_word, down_word;
	int num_errors = 0;
	int total_checks = 0;
	logic [7:0] tag_n = 8'h00; // tag of the next trigger

	bsr_readout #(.LATENCY(LAT)) dut (.mclk(mclk), .nrst(nrst), .hit_in(hit_in),
		.first_level_trigger(first_level_trigger), .sel_mode(sel_mode), .chip_identifier(chip_identifier),
		.config_error(config_error), .test_enable(test_enable), .test_pattern(test_pattern),
		.bypass_sel(bypass_sel), .token_in(token_in), .token_bypass_in(token_bypass_in),
		.token_out(token_out), .up_valid(up_valid), .up_word(up_word), .up_bypass_valid(up_bypass_valid),
		.up_bypass_word(up_bypass_word), .up_ready(up_ready), .down_valid(down_valid),
		.down_ready(down_ready), .down_word(down_word), .buf_error(buf_error));
	bsr_chain_model nb (.mclk(mclk), .nrst(nrst), .token_in(token_in), .token_bypass_in(token_bypass_in),
		.up_valid(up_valid), .up_word(up_word), .up_bypass_valid(up_bypass_valid),
		.up_bypass_word(up_bypass_word), .up_ready(up_ready), .down_valid(down_valid),
		.down_word(down_word), .down_ready(down_ready));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #(bsr_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
	end
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	function automatic bsr_pkg::bsr_word_t get(input int k);
		get = 'x;
		if (k < nb.rx.size()) get = nb.rx[k];
	endfunction
	task automatic err_at(input logic [6:0] code, input int k);
		bsr_pkg::bsr_word_t w;
		w = get(k);
		check(w.kind === bsr_pkg::WK_ERROR && w.tag === {4'h0, chip_identifier} && w.chan === code, "error word");
	endtask
	// three crossings then a trigger on the middle one; tst routes them via the pattern
	task automatic load(input logic [127:0] p, t, n, input logic tst);
		logic [127:0] v;
		for (int i = 0; i <= LAT + 3; i++) begin
			@(negedge mclk);
			v = (i == 0) ? p : (i == 1) ? t : (i == 2) ? n : 128'h0;
			test_pattern = v;
			test_enable = tst && (i < 3);
			hit_in = (tst && i < 3) ? ~v : v;
			first_level_trigger = (i == LAT + 2);
		end
		tag_n++;
	endtask
	// one token turn, waiting for the token to leave
	task automatic turn(input logic byp);
		int i;
		nb.rx.delete();
		nb.give_token(byp);
		for (i = 0; i < 3000; i++) begin
			@(posedge mclk);
			if (token_out === 1'b1) break;
		end
		check(i < 3000, "token never passed on");
		repeat (20) @(posedge mclk);
	endtask
	// header, qualifying hits in channel order, trailer
	task automatic check_event(input bsr_pkg::bsr_mode_t m, input logic [7:0] tg, input logic ls,
		input logic [127:0] p, t, n, inout int k);
		bsr_pkg::bsr_word_t w;
		logic [2:0] b;
		logic q;
		w = get(k);
		k++;
		check(w.kind === bsr_pkg::WK_HEADER && w.tag === tg && w.lost === ls, "header");
		for (int c = 0; c < bsr_pkg::NCHAN; c++) begin
			b = {p[c], t[c], n[c]};
			case (m)
				bsr_pkg::MODE_LEVEL: q = b[1];
				bsr_pkg::MODE_EDGE: q = !b[2] && b[1];
				bsr_pkg::MODE_HIT: q = |b;
				default: q = 1'b1;
			endcase
			if (q) begin
				w = get(k);
				k++;
				check(w.kind === bsr_pkg::WK_HIT && w.chan === 7'(c) && w.bits === b, "hit");
			end
		end
		w = get(k);
		k++;
		check(w.kind === bsr_pkg::WK_TRAILER, "trailer");
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_modes;
		int k;
		for (int mi = 0; mi < 4; mi++) begin
			@(negedge mclk);
			sel_mode = bsr_pkg::bsr_mode_t'(mi);
			nb.slow = (mi == 1);
			load(PV, TV, NV, mi == 3);
			turn(1'b0);
			k = 0;
			check_event(sel_mode, tag_n - 8'h01, 1'b0, PV, TV, NV, k);
			check(k == nb.rx.size(), "extra words");
		end
		nb.slow = 1'b0;
	endtask
	task automatic s_overflow;
		logic [7:0] base;
		int k;
		base = tag_n;
		@(negedge mclk);
		sel_mode = bsr_pkg::MODE_LEVEL;
		repeat (9) load(128'h0, 128'h8, 128'h0, 1'b0);
		for (int i = 1; i <= 8; i++) begin
			turn(1'b0);
			k = 0;
			if (i == 1) begin
				err_at(bsr_pkg::ERR_OVERFLOW, 0);
				k = 1;
			end
			check_event(sel_mode, base + i[7:0], i == 8, 128'h0, 128'h8, 128'h0, k);
		end
		turn(1'b0);
		err_at(bsr_pkg::ERR_NO_DATA, 0);
		check(nb.rx.size() == 1, "extra words after empty readout");
	endtask
	task automatic s_config;
		int k;
		@(negedge mclk);
		config_error = 1'b1;
		load(PV, TV, NV, 1'b0);
		turn(1'b0);
		config_error = 1'b0;
		err_at(bsr_pkg::ERR_CONFIG, 0);
		k = 1;
		check_event(sel_mode, tag_n - 8'h01, 1'b0, PV, TV, NV, k);
	endtask
	task automatic s_forward;
		nb.rx.delete();
		nb.send_up(21'h0a5c3f, 1'b0);
		repeat (6) @(posedge mclk);
		check(nb.rx.size() == 1 && get(0) === 21'h0a5c3f, "forwarded word");
		@(negedge mclk);
		bypass_sel = 1'b1;
		nb.rx.delete();
		nb.send_up(21'h15a3c0, 1'b1);
		repeat (6) @(posedge mclk);
		check(nb.rx.size() == 1 && get(0) === 21'h15a3c0, "bypass word");
		turn(1'b1);
		err_at(bsr_pkg::ERR_NO_DATA, 0);
		@(negedge mclk);
		bypass_sel = 1'b0;
		nb.hold = 1'b1;
		nb.rx.delete();
		nb.send_up(21'h0a5c3f, 1'b0);
		nb.send_up(21'h15a3c0, 1'b0);
		fork
			nb.send_up(21'h1f0f0f, 1'b0);
			begin
				repeat (20) begin
					@(posedge mclk);
					check(up_ready === 1'b0, "word taken while full");
				end
				@(negedge mclk);
				nb.hold = 1'b0;
			end
		join
		repeat (10) @(posedge mclk);
		check(nb.rx.size() == 3 && get(0) === 21'h0a5c3f && get(2) === 21'h1f0f0f, "drain order");
	endtask

	// ------------------------------------------------------------
	// run and verdict
	// ------------------------------------------------------------
	task automatic wrap_up;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#300000;
		num_errors++;
		wrap_up;
	end
	initial begin
		nrst = 1'b0;
		hit_in = 128'h0;
		first_level_trigger = 1'b0;
		sel_mode = bsr_pkg::MODE_LEVEL;
		chip_identifier = 4'h9;
		config_error = 1'b0;
		test_enable = 1'b0;
		test_pattern = 128'h0;
		bypass_sel = 1'b0;
		repeat (4) @(negedge mclk);
		check(token_out === 1'b0 && up_ready === 1'b0 && down_valid === 1'b0 && buf_error === 1'b0, "reset");
		nrst = 1'b1;
		turn(1'b0);
		err_at(bsr_pkg::ERR_NO_DATA, 0);
		s_modes;
		s_overflow;
		s_config;
		s_forward;
		check(buf_error === 1'b0 && nb.timeouts == 0, "bookkeeping error");
		wrap_up;
	end
endmodule
